// >>> hdl/smc_client.sv
// Functional notes
// - start: data falls while clock high
// - stop: data rises while clock high
// - first byte: address then direction bit
// - answer only to address 57h
// - bytes eight bits, msb first
// - ack on ninth clock every received byte except a foreign address or a refused index
// - stop returns interface to idle
// - enabled: clock low 30 ms resets
// - enabled, awake: idle 200 us resets
// - timeouts disabled until bit cleared
// - after timeout wait for new start
// - works from 10 kHz to 400 kHz
// - block transfers without byte count
// - write byte: index then one data
// - read byte: index, restart, read, nack
// - block write advances pointer per byte
// - block read returns successive registers
// - pointer wraps FFh to 00h
// - index then stop only loads pointer
// - second pointer-only write nacked, ignored
// - never stretches the clock
// - plain read uses current pointer
`timescale 1ns/10ps
`default_nettype none
module smc_client #(
    parameter int CNT_W       = 19,
    parameter int TIMEOUT_CYC = smc_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // two-wire bus, clock is input only
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // configuration
    input  wire logic       timeout_disable_bit,
    input  wire logic       sleep,
    // register map access
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (2 ** CNT_W)) begin : g_chk
        $error("timeout count does not fit counter");
    end

    smc_pkg::smc_state_e st_r;
    logic                scl_q_r;
    logic                sda_q_r;
    logic [3:0]          bit_r;
    logic [7:0]          shr_r;
    logic [7:0]          tx_r;
    logic [7:0]          ptr_r;
    logic                first_r;
    logic                got_idx_r;
    logic                got_data_r;
    logic                prev_ptr_r;
    logic                inc_r;
    logic                load_r;
    logic                oe_n_r;
    logic                sda_o_r;
    logic [7:0]          wdata_r;
    logic                wr_r;
    logic                rd_r;
    logic [CNT_W-1:0]    low_cnt_r;
    logic [smc_pkg::IDLE_W-1:0] idle_cnt_r;

    // line events
    wire rise       = scl_i & ~scl_q_r;
    wire fall       = ~scl_i & scl_q_r;
    wire start_det  = scl_i & scl_q_r & sda_q_r & ~sda_i;
    wire stop_det   = scl_i & scl_q_r & ~sda_q_r & sda_i;
    wire byte_end   = fall & (bit_r == smc_pkg::ACK_BIT);
    wire addr_match = shr_r[7:1] == smc_pkg::OWN_ADDR;
    wire dir_rd     = shr_r[0];
    wire host_ack   = rise & (bit_r == smc_pkg::ACK_BIT) & ~sda_i;
    wire to_en      = ~timeout_disable_bit;
    wire [CNT_W-1:0] to_lim = CNT_W'(TIMEOUT_CYC);
    wire [smc_pkg::IDLE_W-1:0] idle_lim =
        smc_pkg::IDLE_W'(smc_pkg::IDLE_CYC);
    wire to_hit     = to_en & ~scl_i & (low_cnt_r == to_lim);
    wire idle_hit   = to_en & ~sleep & scl_i & sda_i
                    & (idle_cnt_r == idle_lim);
    wire proto_rst  = to_hit | idle_hit;
    wire ptr_skip   = first_r & prev_ptr_r;

    assign sda_oe_n  = oe_n_r;
    assign sda_o     = sda_o_r;
    assign reg_addr  = ptr_r;
    assign reg_wdata = wdata_r;
    assign reg_wr    = wr_r;
    assign reg_rd    = rd_r;

    // line sampling
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            sda_o_r <= 1'b0;
        end else begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
            sda_o_r <= 1'b0;
        end
    end

    // timeout counters
    always_ff @(posedge sys_clk) begin
        if (rst || scl_i || !to_en) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != to_lim) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !scl_i || !sda_i || !to_en || sleep) begin
            idle_cnt_r <= '0;
        end else if (idle_cnt_r != idle_lim) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    // protocol sequencing and data line drive
    always_ff @(posedge sys_clk) begin
        if (rst || proto_rst) begin
            st_r   <= smc_pkg::SMC_IDLE;
            bit_r  <= 4'h0;
            oe_n_r <= 1'b1;
        end else if (start_det) begin
            st_r   <= smc_pkg::SMC_ADDR;
            bit_r  <= 4'h0;
            oe_n_r <= 1'b1;
        end else if (stop_det) begin
            st_r   <= smc_pkg::SMC_IDLE;
            oe_n_r <= 1'b1;
        end else begin
            if (rise && st_r != smc_pkg::SMC_IDLE) begin
                if (bit_r == smc_pkg::ACK_BIT) begin
                    bit_r <= 4'h0;
                    if (st_r == smc_pkg::SMC_READ && sda_i) begin
                        st_r <= smc_pkg::SMC_IGNORE;
                    end
                end else begin
                    bit_r <= bit_r + 4'h1;
                end
            end
            if (byte_end) begin
                unique case (st_r)
                    smc_pkg::SMC_ADDR: begin
                        if (addr_match) begin
                            oe_n_r <= 1'b0;
                            st_r   <= dir_rd ? smc_pkg::SMC_READ
                                             : smc_pkg::SMC_WRITE;
                        end else begin
                            st_r   <= smc_pkg::SMC_IGNORE;
                        end
                    end
                    smc_pkg::SMC_WRITE: begin
                        if (ptr_skip) begin
                            st_r   <= smc_pkg::SMC_IGNORE;
                        end else begin
                            oe_n_r <= 1'b0;
                        end
                    end
                    smc_pkg::SMC_READ,
                    smc_pkg::SMC_IDLE,
                    smc_pkg::SMC_IGNORE: oe_n_r <= 1'b1;
                    default: st_r <= smc_pkg::SMC_IDLE;
                endcase
            end else if (fall) begin
                if (st_r == smc_pkg::SMC_READ) begin
                    oe_n_r <= tx_r[7];
                end else begin
                    oe_n_r <= 1'b1;
                end
            end
        end
    end

    // shifting, pointer and register strobes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shr_r      <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= smc_pkg::PTR_RST;
            first_r    <= 1'b0;
            got_idx_r  <= 1'b0;
            got_data_r <= 1'b0;
            prev_ptr_r <= 1'b0;
            inc_r      <= 1'b0;
            load_r     <= 1'b0;
            wdata_r    <= 8'h00;
            wr_r       <= 1'b0;
            rd_r       <= 1'b0;
        end else begin
            wr_r  <= 1'b0;
            rd_r  <= 1'b0;
            inc_r <= wr_r;
            if (inc_r) begin
                ptr_r <= ptr_r + smc_pkg::PTR_STEP;
            end
            if (rise && bit_r < smc_pkg::ACK_BIT) begin
                shr_r <= {shr_r[6:0], sda_i};
            end
            if (start_det) begin
                first_r    <= 1'b1;
                got_idx_r  <= 1'b0;
                got_data_r <= 1'b0;
            end
            if (stop_det && st_r == smc_pkg::SMC_WRITE) begin
                prev_ptr_r <= got_idx_r & ~got_data_r;
            end
            load_r <= 1'b0;
            if (host_ack && oe_n_r && st_r == smc_pkg::SMC_READ) begin
                ptr_r  <= ptr_r + smc_pkg::PTR_STEP;
                load_r <= 1'b1;
            end
            if (load_r) begin
                tx_r <= reg_rdata;
                rd_r <= 1'b1;
            end
            if (byte_end && st_r == smc_pkg::SMC_ADDR && addr_match
                && dir_rd) begin
                tx_r       <= reg_rdata;
                rd_r       <= 1'b1;
                prev_ptr_r <= 1'b0;
            end else if (byte_end && st_r == smc_pkg::SMC_WRITE) begin
                if (first_r) begin
                    if (!prev_ptr_r) begin
                        ptr_r     <= shr_r;
                        first_r   <= 1'b0;
                        got_idx_r <= 1'b1;
                    end
                end else begin
                    wdata_r    <= shr_r;
                    wr_r       <= 1'b1;
                    got_data_r <= 1'b1;
                    prev_ptr_r <= 1'b0;
                end
            end else if (fall && st_r == smc_pkg::SMC_READ) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // checks
    property p_start;
        @(posedge sys_clk) disable iff (rst)
        (start_det && !proto_rst) |=>
            (st_r == smc_pkg::SMC_ADDR) && (bit_r == 4'h0) && oe_n_r;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    property p_stop;
        @(posedge sys_clk) disable iff (rst)
        (stop_det && !start_det) |=>
            (st_r == smc_pkg::SMC_IDLE) && oe_n_r;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not idle the client");

    property p_addr_ack;
        @(posedge sys_clk) disable iff (rst)
        (byte_end && !proto_rst && !start_det && !stop_det
         && st_r == smc_pkg::SMC_ADDR && addr_match) |=>
            !oe_n_r && (st_r == ($past(dir_rd) ? smc_pkg::SMC_READ
                                               : smc_pkg::SMC_WRITE));
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acked");

    property p_foreign;
        @(posedge sys_clk) disable iff (rst)
        (byte_end && !proto_rst && !start_det && !stop_det
         && st_r == smc_pkg::SMC_ADDR && !addr_match) |=>
            (st_r == smc_pkg::SMC_IGNORE) && oe_n_r;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign address not ignored");

    property p_wr_inc;
        @(posedge sys_clk) disable iff (rst)
        wr_r |-> ##2 (ptr_r == $past(ptr_r, 2) + smc_pkg::PTR_STEP);
    endproperty
    a_wr_inc: assert property (p_wr_inc)
        else $error("pointer not advanced after write");

    property p_timeout;
        @(posedge sys_clk) disable iff (rst)
        (to_en && !scl_i && low_cnt_r == to_lim) |=>
            (st_r == smc_pkg::SMC_IDLE);
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("clock low timeout missed");

    property p_idle;
        @(posedge sys_clk) disable iff (rst)
        (to_en && !sleep && scl_i && sda_i && idle_cnt_r == idle_lim)
            |=> (st_r == smc_pkg::SMC_IDLE);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle reset missed");

    property p_dis;
        @(posedge sys_clk) disable iff (rst)
        timeout_disable_bit |=> (low_cnt_r == '0) && (idle_cnt_r == '0);
    endproperty
    a_dis: assert property (p_dis)
        else $error("timeout counted while disabled");

    property p_ptr_skip;
        @(posedge sys_clk) disable iff (rst)
        (byte_end && !proto_rst && !start_det && !stop_det
         && st_r == smc_pkg::SMC_WRITE && ptr_skip) |=>
            oe_n_r && (st_r == smc_pkg::SMC_IGNORE) && $stable(ptr_r);
    endproperty
    a_ptr_skip: assert property (p_ptr_skip)
        else $error("repeated pointer write not refused");

    property p_msb;
        @(posedge sys_clk) disable iff (rst)
        (fall && !byte_end && !proto_rst && !start_det && !stop_det
         && st_r == smc_pkg::SMC_READ) |=> (oe_n_r == $past(tx_r[7]));
    endproperty
    a_msb: assert property (p_msb)
        else $error("read bit order wrong");
endmodule : smc_client
`default_nettype wire

// >>> pkg/smc_pkg.sv
`default_nettype none
package smc_pkg;
    // system clock rate and bus timing
    localparam int         SYS_CLK_HZ  = 10_000_000;
    localparam int         TIMEOUT_MS  = 30;
    localparam int         TIMEOUT_CYC = SYS_CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int         IDLE_US     = 200;
    localparam int         IDLE_CYC    = SYS_CLK_HZ / 1_000_000 * IDLE_US;
    localparam int         IDLE_W      = 12;
    // client address and byte framing
    localparam logic [6:0] OWN_ADDR    = 7'h57;
    localparam logic [3:0] ACK_BIT     = 4'h8;
    localparam logic [7:0] PTR_RST     = 8'h00;
    localparam logic [7:0] PTR_STEP    = 8'h01;

    typedef enum logic [2:0] {
        SMC_IDLE   = 3'b000,
        SMC_ADDR   = 3'b001,
        SMC_WRITE  = 3'b010,
        SMC_READ   = 3'b011,
        SMC_IGNORE = 3'b100
    } smc_state_e;
endpackage : smc_pkg
`default_nettype wire

// >>> tb/smc_regmap.sv
`timescale 1ns/10ps
`default_nettype none
module smc_regmap (
    // clock
    input  wire logic       sys_clk,
    // register access
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    output logic [7:0]      reg_rdata
);
    logic [7:0] mem [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    // combinational read of current pointer
    assign reg_rdata = mem[reg_addr];

    always @(posedge sys_clk) begin
        if (reg_wr) begin
            mem[reg_addr] <= reg_wdata;
        end
    end
endmodule : smc_regmap
`default_nettype wire

// >>> tb/smbus_i2c_client_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_i2c_client_port_tb;
    logic       sys_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       scl       = 1'b1;
    logic       hs        = 1'b1;
    logic       dis       = 1'b1;
    logic       slp       = 1'b0;
    logic       sda_o;
    logic       sda_oe_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] sh [0:255];
    logic [7:0] p1;
    logic [6:0] fa;
    wire logic  sda;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc       = 0;
    int         rd_cnt    = 0;
    int         rd0       = 0;

    // open-drain data wire, host pulls up when released
    assign sda = sda_oe_n ? hs : sda_o;
    always #50 sys_clk = ~sys_clk;

    smc_client #(.TIMEOUT_CYC(200)) u_dut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .scl_i               (scl),
        .sda_i               (sda),
        .sda_o               (sda_o),
        .sda_oe_n            (sda_oe_n),
        .timeout_disable_bit (dis),
        .sleep               (slp),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata)
    );

    smc_regmap u_map (
        .sys_clk   (sys_clk),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rdata (reg_rdata)
    );

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (reg_rd) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic w4();
        repeat (4) @(posedge sys_clk);
    endtask : w4

    // one clock pulse, data set while clock low
    task automatic bx(input logic b, output logic r);
        hs <= b;
        w4();
        scl <= 1'b1;
        w4();
        r = sda;
        scl <= 1'b0;
        w4();
    endtask : bx

    task automatic start_c();
        hs <= 1'b1;
        w4();
        scl <= 1'b1;
        w4();
        hs <= 1'b0;
        w4();
        scl <= 1'b0;
        w4();
    endtask : start_c

    task automatic stop_c();
        hs <= 1'b0;
        w4();
        scl <= 1'b1;
        w4();
        hs <= 1'b1;
        w4();
    endtask : stop_c

    // send msb first, then sample the ninth bit
    task automatic wb(input logic [7:0] v, input logic nk);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bx(v[i], r);
        end
        bx(1'b1, r);
        chk({7'h00, nk}, {7'h00, r});
    endtask : wb

    task automatic rb(input logic nk, input logic [7:0] e);
        logic [7:0] v;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            bx(1'b1, r);
            v[i] = r;
        end
        bx(nk, r);
        chk(e, v);
    endtask : rb

    task automatic wr_at(input logic [7:0] idx, input int n);
        logic [7:0] d;
        start_c();
        wb(8'hAE, 1'b0);
        wb(idx, 1'b0);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            wb(d, 1'b0);
            sh[8'(idx + k)] = d;
        end
        stop_c();
    endtask : wr_at

    task automatic rd_at(input logic [7:0] idx, input int n);
        int c0;
        start_c();
        wb(8'hAE, 1'b0);
        wb(idx, 1'b0);
        c0 = rd_cnt;
        start_c();
        wb(8'hAF, 1'b0);
        for (int k = 0; k < n; k++) begin
            rb(k == n - 1, sh[8'(idx + k)]);
        end
        stop_c();
        chk(8'(n), 8'(rd_cnt - c0));
    endtask : rd_at

    // clock held low or high mid-transfer, then an index byte
    task automatic stall(input logic hi, input int n, input logic nk);
        logic       r;
        logic [7:0] d;
        start_c();
        wb(8'hAE, 1'b0);
        hs <= 1'b1;
        w4();
        scl <= hi;
        repeat (n) @(posedge sys_clk);
        scl <= 1'b0;
        w4();
        for (int i = 0; i < (hi ? 7 : 8); i++) begin
            bx(1'b1, r);
        end
        bx(1'b1, r);
        chk({7'h00, nk}, {7'h00, r});
        if (!nk) begin
            d = 8'($urandom);
            wb(d, 1'b0);
            sh[8'hFF] = d;
        end
        stop_c();
    endtask : stall

    initial begin
        void'($urandom(32'h01F9));
        for (int i = 0; i < 256; i++) begin
            sh[i] = 8'(i) ^ 8'hA5;
        end
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        w4();
        p1 = 8'($urandom);
        wr_at(p1, 1);
        rd_at(p1, 1);
        $display("test single byte done");
        wr_at(8'hFE, 4);
        rd_at(8'hFD, 6);
        $display("test block wrap done");
        fa = 7'($urandom);
        if (fa == 7'h57) begin
            fa = 7'h56;
        end
        start_c();
        wb({fa, 1'b0}, 1'b1);
        stop_c();
        $display("test foreign address done");
        start_c();
        wb(8'hAE, 1'b0);
        wb(p1, 1'b0);
        stop_c();
        start_c();
        wb(8'hAE, 1'b0);
        wb(~p1, 1'b1);
        stop_c();
        rd0 = rd_cnt;
        for (int k = 0; k < 2; k++) begin
            start_c();
            wb(8'hAF, 1'b0);
            rb(1'b1, sh[p1]);
            stop_c();
        end
        chk(8'h02, 8'(rd_cnt - rd0));
        $display("test pointer only done");
        stall(1'b0, 300, 1'b0);
        dis <= 1'b0;
        stall(1'b0, 300, 1'b1);
        stall(1'b1, 2100, 1'b1);
        slp <= 1'b1;
        stall(1'b1, 2100, 1'b0);
        slp <= 1'b0;
        rd_at(8'hFF, 2);
        $display("test timeouts done");
        end_sim();
    end
endmodule : smbus_i2c_client_port_tb
`default_nettype wire
